//--- rtl/socfg_pkg.sv
// package for the sensor configuration array: offsets, fields, reset values
package socfg_pkg;

   // ****************************************************************
   // array geometry
   // ****************************************************************
   localparam int         SOCFG_NUM_LOC    = 14;
   localparam logic [4:0] SOCFG_BYTE_AW    = 5'h0E;
   localparam int         SOCFG_CRC_W      = 8;

   // ****************************************************************
   // byte offsets
   // ****************************************************************
   localparam logic [3:0] SERIAL_BYTE0_OFS  = 4'h0;
   localparam logic [3:0] SERIAL_BYTE3_OFS  = 4'h3;
   localparam logic [3:0] FACTORY_RANGE_OFS = 4'h4;
   localparam logic [3:0] LINK_OPTIONS_OFS  = 4'h5;
   localparam logic [3:0] USER_FIRST_OFS    = 4'h5;
   localparam logic [3:0] USER_LAST_OFS     = 4'hB;
   localparam logic [3:0] STATUS_FLAGS_OFS  = 4'hC;
   localparam logic [3:0] MAKER_ID_OFS      = 4'hD;

   // ****************************************************************
   // field positions and reset values
   // ****************************************************************
   localparam int         UNIT_LSB         = 0;
   localparam int         UNIT_MSB         = 12;
   localparam int         LOT_LSB          = 13;
   localparam int         LOT_MSB          = 31;
   localparam logic [4:0] RANGE_FIXED_PAT  = 5'h04;
   localparam int         LOCK_BIT         = 7;
   localparam int         PULSE_EN_BIT     = 6;
   localparam int         SYNC_PULLDOWN_ENABLE_BIT      = 5;
   localparam int         LATENCY_BIT      = 4;
   localparam int         WORD_LEN_BIT     = 3;
   localparam int         BLANK_BIT        = 2;
   localparam int         CHECK_BIT        = 1;
   localparam int         BAUD_BIT         = 0;
   localparam logic [7:0] USER_DEFAULT     = 8'h00;
   localparam logic [7:0] RANGE_RESET      = 8'h20;

   // range codes
   localparam logic [2:0] RANGE_60G        = 3'h1;
   localparam logic [2:0] RANGE_120G       = 3'h3;
   localparam logic [2:0] RANGE_240G       = 3'h5;
   localparam logic [2:0] RANGE_480G       = 3'h7;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int         PROG_TIME_NS     = 100;
   localparam int         CLK_PERIOD_NS    = 10;
   localparam int         PROG_CYCLES      = PROG_TIME_NS / CLK_PERIOD_NS;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef enum logic [1:0] {
      SOCFG_FULL_RANGE_RSV,
      SOCFG_FULL_RANGE_MED,
      SOCFG_FULL_RANGE_HIGH
   } socfg_cell_t;

   // decoded link options carried to the rest of the sensor
   typedef struct packed {
      logic sync_pulldown_enable;
      logic latency_select;
      logic word_length_select;
      logic blanking_select;
      logic check_code_select;
      logic baud_select;
   } socfg_link_opts_t;

   // link access request: byte or nibble addressing
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic       nibble_mode;
      logic [4:0] addr;
      logic [7:0] wdata;
   } socfg_req_t;

endpackage

//--- rtl/socfg_array.sv
// user-accessible configuration and identification array
`timescale 1ns/1ps

module socfg_array
   import socfg_pkg::*;
#(
   parameter logic [31:0] UNIT_LOT_WORD = 32'h00002001,
   parameter logic [2:0]  RANGE_CODE    = 3'h1,
   // arbitrary neutral value, no real maker code
   parameter logic [7:0]  MAKER_ID_DFLT = 8'h5A,
   parameter logic [7:0]  TRIM_VALUE    = 8'hA5
) (
   // clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // link access port
   input  wire socfg_req_t        link_req,
   input  wire logic              exec_prog,
   output logic                   rd_valid,
   output logic [7:0]             rd_data,
   output logic                   wr_refused,
   output logic                   prog_busy,
   // status from the sensor core
   input  wire logic [7:0]        core_status,
   input  wire logic              pcm_stream,
   // configuration outputs
   output socfg_link_opts_t       link_opts,
   output logic                   pcm_out,
   output logic [2:0]             range_code,
   output socfg_cell_t            cell_kind,
   output logic                   user_locked,
   output logic                   user_check_en,
   output logic                   factory_fault,
   output logic                   user_fault
);

   // ****************************************************************
   // storage
   // ****************************************************************
   // factory block: identification, range, trim
   logic [7:0] fact_mem [0:4];
   logic [7:0] trim_r;
   logic [7:0] fact_crc_r;
   // user block: shadow written by link, OTP image burned on execute
   logic [7:0] user_shadow_r [0:7];
   logic [7:0] user_otp_r    [0:7];
   logic [7:0] user_crc_r;
   logic       lock_r;
   logic       check_r;
   logic [3:0] prog_cnt_r;
   logic       prog_r;
   logic       readout_r;

   // map a byte offset into the user index (offsets 5..B and D)
   function automatic logic [2:0] user_idx(input logic [3:0] ofs);
      logic [2:0] i;
      i = 3'h0;
      if (ofs == MAKER_ID_OFS) begin
         i = 3'h7;
      end else begin
         i = 3'(ofs - USER_FIRST_OFS);
      end
      return i;
   endfunction

   // simple xor-rotate check byte; per block so faults stay separate
   function automatic logic [7:0] chk(input logic [7:0] a, input logic [7:0] b);
      return {a[6:0], a[7]} ^ b;
   endfunction

   // ****************************************************************
   // factory block contents
   // ****************************************************************
   // fixed at build; unit and lot fields fit 13 and 19 bits
   // numbering from 1 is the build parameter's job
   always_comb begin
      fact_mem[0] = UNIT_LOT_WORD[7:0];
      fact_mem[1] = UNIT_LOT_WORD[15:8];
      fact_mem[2] = UNIT_LOT_WORD[23:16];
      fact_mem[3] = UNIT_LOT_WORD[31:24];
      // upper five bits hardwired, low three range code
      fact_mem[4] = {RANGE_FIXED_PAT, RANGE_CODE};
   end

   // trim value is reachable only from inside the core
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         trim_r <= 8'h00;
      end else begin
         trim_r <= TRIM_VALUE;
      end
   end

   // ****************************************************************
   // address decode
   // ****************************************************************
   logic [3:0] byte_ofs;
   logic       hi_nib;
   logic       is_user;
   logic       is_mapped;
   always_comb begin
      // nibble addressing: byte = addr/2, odd picks upper half
      if (link_req.nibble_mode) begin
         byte_ofs = link_req.addr[4:1];
         hi_nib   = link_req.addr[0];
      end else begin
         byte_ofs = link_req.addr[3:0];
         hi_nib   = 1'b0;
      end
      is_mapped = (link_req.nibble_mode || !link_req.addr[4]) &&
                  (byte_ofs <= MAKER_ID_OFS);
      is_user   = is_mapped && ((byte_ofs >= USER_FIRST_OFS &&
                  byte_ofs <= USER_LAST_OFS) || byte_ofs == MAKER_ID_OFS);
   end

   // ****************************************************************
   // shadow writes from the link
   // ****************************************************************
   // besides the readout reload, only link writes reach user locations, never after lock
   logic wr_ok;
   // readout cycle counts as busy, else its reload would eat the write
   assign wr_ok = link_req.wr && is_user && !lock_r && !prog_r &&
                  !readout_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 7; i++) begin
            user_shadow_r[i] <= USER_DEFAULT;
         end
         user_shadow_r[7] <= MAKER_ID_DFLT;
      end else if (readout_r) begin
         // readout reloads shadow from the burned image
         for (int i = 0; i < 8; i++) begin
            user_shadow_r[i] <= user_otp_r[i];
         end
      end else if (wr_ok) begin
         if (!link_req.nibble_mode) begin
            user_shadow_r[user_idx(byte_ofs)] <= link_req.wdata;
         end else if (hi_nib) begin
            user_shadow_r[user_idx(byte_ofs)][7:4] <= link_req.wdata[3:0];
         end else begin
            user_shadow_r[user_idx(byte_ofs)][3:0] <= link_req.wdata[3:0];
         end
      end
   end

   // refused write indication, one cycle
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_refused <= 1'b0;
      end else begin
         wr_refused <= link_req.wr && !wr_ok;
      end
   end

   // ****************************************************************
   // programming sequence
   // ****************************************************************
   // burn takes a fixed time, then a readout cycle follows
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prog_r     <= 1'b0;
         prog_cnt_r <= 4'h0;
         readout_r  <= 1'b0;
      end else begin
         readout_r <= 1'b0;
         if (prog_r) begin
            if (prog_cnt_r == 4'(PROG_CYCLES - 1)) begin
               prog_r    <= 1'b0;
               readout_r <= 1'b1;
            end else begin
               prog_cnt_r <= prog_cnt_r + 4'h1;
            end
         end else if (exec_prog && !lock_r && !readout_r) begin
            prog_r     <= 1'b1;
            prog_cnt_r <= 4'h0;
         end
      end
   end

   // OTP image: defaults zero except the maker ID byte, frozen once locked
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         for (int i = 0; i < 7; i++) begin
            user_otp_r[i] <= USER_DEFAULT;
         end
         user_otp_r[7] <= MAKER_ID_DFLT;
      end else if (prog_r && prog_cnt_r == 4'h0 && !lock_r) begin
         // OTP bits can only go from 0 to 1
         for (int i = 0; i < 8; i++) begin
            user_otp_r[i] <= user_otp_r[i] | user_shadow_r[i];
         end
      end
   end

   // lock and user check take effect at readout
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lock_r  <= 1'b0;
         check_r <= 1'b0;
      end else if (readout_r && user_otp_r[0][LOCK_BIT]) begin
         lock_r  <= 1'b1;
         check_r <= 1'b1;
      end
   end

   // ****************************************************************
   // independent check logic for the two blocks
   // ****************************************************************
   // factory check covers identification and range
   logic [7:0] fact_calc;
   logic [7:0] user_calc;
   always_comb begin
      fact_calc = 8'h00;
      for (int i = 0; i < 5; i++) begin
         fact_calc = chk(fact_calc, fact_mem[i]);
      end
      user_calc = 8'h00;
      for (int i = 0; i < 8; i++) begin
         user_calc = chk(user_calc, user_otp_r[i]);
      end
   end

   // factory reference check byte reloaded every cycle, user one captured at each readout
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fact_crc_r <= 8'h00;
         user_crc_r <= 8'h00;
      end else begin
         fact_crc_r <= fact_calc;
         if (readout_r) begin
            user_crc_r <= user_calc;
         end
      end
   end

   // faults flagged per block; user check only once locked
   logic fact_armed_r;
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fact_armed_r  <= 1'b0;
         factory_fault <= 1'b0;
         user_fault    <= 1'b0;
      end else begin
         fact_armed_r  <= 1'b1;
         factory_fault <= fact_armed_r && (fact_crc_r != fact_calc);
         user_fault    <= check_r && !readout_r &&
                          (user_crc_r != user_calc);
      end
   end

   // ****************************************************************
   // read path
   // ****************************************************************
   // every readable location returned, next cycle
   logic [7:0] rd_byte;
   always_comb begin
      rd_byte = 8'h00;
      if (!is_mapped) begin
         rd_byte = 8'h00;
      end else if (byte_ofs <= FACTORY_RANGE_OFS) begin
         rd_byte = fact_mem[byte_ofs[2:0]];
      end else if (byte_ofs == STATUS_FLAGS_OFS) begin
         rd_byte = {1'b0, core_status[6:1], 1'b0};
      end else begin
         rd_byte = user_shadow_r[user_idx(byte_ofs)];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
      end else begin
         rd_valid <= link_req.rd;
         if (link_req.rd) begin
            // nibble reads land in the low four bits
            if (!link_req.nibble_mode) begin
               rd_data <= rd_byte;
            end else if (hi_nib) begin
               rd_data <= {4'h0, rd_byte[7:4]};
            end else begin
               rd_data <= {4'h0, rd_byte[3:0]};
            end
         end
      end
   end

   // ****************************************************************
   // configuration outputs
   // ****************************************************************
   // options follow the active shadow copy
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         link_opts   <= '0;
         pcm_out     <= 1'b0;
         user_locked <= 1'b0;
         prog_busy   <= 1'b0;
      end else begin
         link_opts.sync_pulldown_enable <= user_shadow_r[0][SYNC_PULLDOWN_ENABLE_BIT];
         link_opts.latency_select       <= user_shadow_r[0][LATENCY_BIT];
         link_opts.word_length_select   <= user_shadow_r[0][WORD_LEN_BIT];
         link_opts.blanking_select      <= user_shadow_r[0][BLANK_BIT];
         link_opts.check_code_select    <= user_shadow_r[0][CHECK_BIT];
         link_opts.baud_select          <= user_shadow_r[0][BAUD_BIT];
         // pulse stream when enabled, else held low
         pcm_out     <= user_shadow_r[0][PULSE_EN_BIT] & pcm_stream;
         user_locked <= lock_r;
         prog_busy   <= prog_r | readout_r;
      end
   end

   // range decode; even codes reserved
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         range_code    <= 3'h0;
         cell_kind     <= SOCFG_FULL_RANGE_RSV;
         user_check_en <= 1'b0;
      end else begin
         range_code    <= RANGE_CODE;
         user_check_en <= check_r;
         case (RANGE_CODE)
            RANGE_60G, RANGE_120G:  cell_kind <= SOCFG_FULL_RANGE_MED;
            RANGE_240G, RANGE_480G: cell_kind <= SOCFG_FULL_RANGE_HIGH;
            default:                cell_kind <= SOCFG_FULL_RANGE_RSV;
         endcase
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   pcm_low_a: assert property (
      !user_shadow_r[0][PULSE_EN_BIT] |=> !pcm_out)
      else $error("pulse output not low while disabled");
   pcm_follow_a: assert property (
      user_shadow_r[0][PULSE_EN_BIT] |=> pcm_out == $past(pcm_stream))
      else $error("pulse output not following stream");
   locked_frozen_a: assert property (
      lock_r |=> $stable(user_otp_r[0]) && $stable(user_otp_r[7]))
      else $error("user image changed after lock");
   lock_wr_a: assert property (
      lock_r && link_req.wr |=> wr_refused)
      else $error("write accepted after lock");
   read_ans_a: assert property (
      link_req.rd |=> rd_valid)
      else $error("read not answered next cycle");
   range_pat_a: assert property (
      link_req.rd && !link_req.nibble_mode &&
      link_req.addr == {1'b0, FACTORY_RANGE_OFS}
      |=> rd_data[7:3] == RANGE_FIXED_PAT)
      else $error("range register fixed bits wrong");
   nib_hi_a: assert property (
      link_req.rd && link_req.nibble_mode && link_req.addr == 5'h09
      |=> rd_data == {4'h0, RANGE_FIXED_PAT[4:1]})
      else $error("nibble map wrong");
   lock_check_a: assert property (
      readout_r && user_otp_r[0][LOCK_BIT] |=> lock_r && check_r)
      else $error("lock readout missed");
   prog_len_a: assert property (
      $rose(prog_r) |-> ##(PROG_CYCLES) readout_r)
      else $error("programming time wrong");

   prog_c: cover property ($rose(prog_r));
   lock_c: cover property ($rose(lock_r));
   nib_c:  cover property (link_req.rd && link_req.nibble_mode);
   pcm_c:  cover property (pcm_out);

endmodule

//--- verif/socfg_link_host.sv
// link-side model: remote receiver issuing reads, writes and programming
`timescale 1ns/1ps

module socfg_link_host
   import socfg_pkg::*;
(
   // clock
   input  wire logic       ref_clk,
   // answers from the array
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   input  wire logic       wr_refused,
   // requests to the array
   output socfg_req_t      link_req,
   output logic            exec_prog
);
   // idle cycles before each read or write request, so a slow receiver can be shown
   int unsigned gap = 0;

   // ****************************************************************
   // request tasks
   // ****************************************************************
   initial begin
      link_req = '0;
      exec_prog = 1'b0;
   end

   // one-cycle request; ends just after the edge that answers it
   task automatic pulse(input logic rd, input logic nib,
                        input logic [4:0] a, input logic [7:0] wd);
      repeat (gap) @(posedge ref_clk);
      @(posedge ref_clk);
      link_req <= '{rd: rd, wr: !rd, nibble_mode: nib, addr: a, wdata: wd};
      @(posedge ref_clk);
      link_req.rd <= 1'b0;
      link_req.wr <= 1'b0;
      // stale data must not look valid once released
      link_req.wdata <= ~wd;
      #1;
   endtask

   task automatic rd_byte(input logic nib, input logic [4:0] a,
                          output logic [7:0] d, output logic v);
      pulse(1'b1, nib, a, 8'h00);
      d = rd_data;
      v = rd_valid;
   endtask

   // user locations change only through these link writes and the array's readout reload after programming
   task automatic wr_byte(input logic nib, input logic [4:0] a,
                          input logic [7:0] wd, output logic refused);
      pulse(1'b0, nib, a, wd);
      refused = wr_refused;
   endtask

   // execute-programming command, single pulse
   task automatic exec();
      @(posedge ref_clk);
      exec_prog <= 1'b1;
      @(posedge ref_clk);
      exec_prog <= 1'b0;
      #1;
   endtask
endmodule

//--- verif/testbench.sv
// self-checking bench for the configuration array
`timescale 1ns/1ps

module testbench;
   import socfg_pkg::*;

   localparam logic [31:0] SN_WORD = 32'h00004003;  // lot 2, unit 3
   localparam logic [2:0]  RCODE   = 3'h3;
   localparam logic [7:0]  MAKER   = 8'h5A;          // arbitrary value

   logic             ref_clk = 1'b0;
   logic             rst = 1'b1;
   socfg_req_t       link_req;
   logic             exec_prog;
   logic             rd_valid;
   logic [7:0]       rd_data;
   logic             wr_refused;
   logic             prog_busy;
   logic [7:0]       core_status = 8'hFF;
   logic             pcm_stream = 1'b0;
   socfg_link_opts_t link_opts;
   logic             pcm_out;
   logic [2:0]       range_code;
   socfg_cell_t      cell_kind;
   logic             user_locked;
   logic             user_check_en;
   logic             factory_fault;
   logic             user_fault;
   int               error_cnt = 0;
   int               cmp_count = 0;
   logic [31:0]      word;
   logic [7:0]       d;
   logic             v;
   int               n;

   // ****************************************************************
   // clock, design and receiver model
   // ****************************************************************
   always #5 ref_clk = ~ref_clk;

   socfg_array #(.UNIT_LOT_WORD(SN_WORD), .RANGE_CODE(RCODE),
                 .MAKER_ID_DFLT(MAKER)) i_dut (
      .ref_clk(ref_clk), .rst(rst), .link_req(link_req),
      .exec_prog(exec_prog), .rd_valid(rd_valid), .rd_data(rd_data),
      .wr_refused(wr_refused), .prog_busy(prog_busy),
      .core_status(core_status), .pcm_stream(pcm_stream),
      .link_opts(link_opts), .pcm_out(pcm_out), .range_code(range_code),
      .cell_kind(cell_kind), .user_locked(user_locked),
      .user_check_en(user_check_en), .factory_fault(factory_fault),
      .user_fault(user_fault));

   socfg_link_host i_host (
      .ref_clk(ref_clk), .rd_valid(rd_valid), .rd_data(rd_data),
      .wr_refused(wr_refused), .link_req(link_req), .exec_prog(exec_prog));

   // ****************************************************************
   // compare and access tasks
   // ****************************************************************
   task automatic check(input string name, input logic [7:0] seen,
                        input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rd_chk(input string name, input logic nib,
                         input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] rd;
      logic       ok;
      i_host.rd_byte(nib, a, rd, ok);
      check({name, " valid"}, {7'h00, ok}, 8'h01);
      check(name, rd, exp);
   endtask

   task automatic wr_chk(input string name, input logic nib,
                         input logic [4:0] a, input logic [7:0] wd,
                         input logic exp_ref);
      logic r;
      i_host.wr_byte(nib, a, wd, r);
      check({name, " refused"}, {7'h00, r}, {7'h00, exp_ref});
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ****************************************************************
   // watchdog, far longer than the whole sequence needs
   // ****************************************************************
   initial begin
      #50000;
      error_cnt++;
      $display("watchdog expired");
      wrap_up();
   end

   // ****************************************************************
   // test sequence
   // ****************************************************************
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      // identification word and factory range, read byte-wise
      for (int i = 0; i < 4; i++) begin
         i_host.rd_byte(1'b0, 5'(i), d, v);
         word[8*i +: 8] = d;
      end
      check("serial word low", word[7:0], SN_WORD[7:0]);
      check("unit number", 8'(word[12:0]), 8'h03);
      check("lot number", 8'(word[31:13]), 8'h02);
      rd_chk("range reg", 1'b0, 5'h04, {RANGE_FIXED_PAT, RCODE});
      check("range out", 8'(range_code), 8'(RCODE));
      check("cell", 8'(cell_kind), 8'(SOCFG_FULL_RANGE_MED));
      rd_chk("link default", 1'b0, 5'h05, USER_DEFAULT);
      rd_chk("status", 1'b0, 5'h0C, 8'h7E);
      rd_chk("maker id", 1'b0, 5'h0D, MAKER);
      check("factory fault", {7'h00, factory_fault}, 8'h00);
      $display("test identification done");
      // read-only and unmapped places refuse writes
      wr_chk("serial write", 1'b0, 5'h02, 8'hFF, 1'b1);
      wr_chk("range write", 1'b0, 5'h04, 8'h27, 1'b1);
      rd_chk("range kept", 1'b0, 5'h04, {RANGE_FIXED_PAT, RCODE});
      wr_chk("status write", 1'b0, 5'h0C, 8'h00, 1'b1);
      wr_chk("unmapped write", 1'b0, 5'h0E, 8'h11, 1'b1);
      rd_chk("unmapped read", 1'b0, 5'h0E, 8'h00);
      $display("test protection done");
      // nibble addressing, receiver slowed by idle gaps
      i_host.gap = 2;
      rd_chk("nib range lo", 1'b1, 5'h08, {5'h00, RCODE});
      rd_chk("nib range hi", 1'b1, 5'h09, 8'h02);
      rd_chk("nib serial", 1'b1, 5'h01, {4'h0, SN_WORD[7:4]});
      wr_chk("nib write lo", 1'b1, 5'h0C, 8'h05, 1'b0);
      wr_chk("nib write hi", 1'b1, 5'h0D, 8'h0A, 1'b0);
      rd_chk("nib byte", 1'b0, 5'h06, 8'hA5);
      rd_chk("nib read", 1'b1, 5'h0D, 8'h0A);
      i_host.gap = 0;
      // back-to-back writes and reads; 0x0C is status, read-only
      for (int a = 7; a <= 13; a++)
         wr_chk("user write", 1'b0, 5'(a), 8'(a * 17), a == 12);
      for (int a = 7; a <= 13; a++) begin
         d = (a == 12) ? 8'h7E : 8'(a * 17);
         rd_chk("user read", 1'b0, 5'(a), d);
      end
      $display("test nibble and user done");
      // link option fields and the pulse-code output pin
      wr_chk("opts a", 1'b0, 5'h05, 8'h6A, 1'b0);
      repeat (2) @(posedge ref_clk);
      check("opts a out", 8'(link_opts), 8'h2A);
      pcm_stream <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("pcm high", {7'h00, pcm_out}, 8'h01);
      pcm_stream <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("pcm low", {7'h00, pcm_out}, 8'h00);
      wr_chk("opts b", 1'b0, 5'h05, 8'h15, 1'b0);
      pcm_stream <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check("opts b out", 8'(link_opts), 8'h15);
      check("pcm forced", {7'h00, pcm_out}, 8'h00);
      $display("test options done");
      // programming with the lock bit, then every write refused
      wr_chk("lock set", 1'b0, 5'h05, 8'hBF, 1'b0);
      check("not locked", {7'h00, user_locked}, 8'h00);
      i_host.exec();
      // busy flag is registered, one edge behind the accepted command
      @(posedge ref_clk);
      #1;
      check("busy", {7'h00, prog_busy}, 8'h01);
      wr_chk("busy write", 1'b0, 5'h07, 8'h00, 1'b1);
      n = 0;
      while (prog_busy === 1'b1 && n < 40) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check("busy ends", {7'h00, prog_busy}, 8'h00);
      check("locked", {7'h00, user_locked}, 8'h01);
      check("user check on", {7'h00, user_check_en}, 8'h01);
      check("user fault", {7'h00, user_fault}, 8'h00);
      wr_chk("locked write", 1'b0, 5'h06, 8'h00, 1'b1);
      wr_chk("locked nib", 1'b1, 5'h0A, 8'h00, 1'b1);
      rd_chk("locked keep", 1'b0, 5'h06, 8'hA5);
      rd_chk("locked opts", 1'b0, 5'h05, 8'hBF);
      i_host.exec();
      // wait the same edge at which an accepted command shows busy
      @(posedge ref_clk);
      #1;
      check("exec ignored", {7'h00, prog_busy}, 8'h00);
      $display("test programming done");
      wrap_up();
   end
endmodule
